// >>> rtl/mcpr_ctrl.v
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "mcpr_defines.vh"
// clock, power management and reset control with apb register access
module mcpr_ctrl (
  // clock and reset
  input  wire        clock,
  input  wire        resetn,
  // pins
  input  wire        osc_input_pin,
  input  wire        rst_pin,
  // interrupt logic
  input  wire        irq_pending,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // clocks, power, machine strobe and core reset
  output reg         osc_enable,
  output reg         cpu_clk,
  output reg         periph_clk,
  output reg         machine_strobe,
  output reg         core_reset,
  // reset-loaded state, and the serial buffer that reset leaves alone
  output reg  [31:0] port_latch,
  output reg  [7:0]  stack_ptr,
  output reg  [7:0]  power_control_reg,
  output reg  [7:0]  special_function_register,
  output reg  [7:0]  serial_buffer
);
  wire                     osc_edge;
  wire                     int_clk;
  wire [`MCPR_PHASE_W-1:0] phase;
  wire                     state5_phase2;
  wire                     rst_active;
  wire                     pwrdn_mode;
  wire                     idle_mode;
  wire                     rst_sample;
  wire                     access;
  wire                     wr_done;
  reg  [7:0]               power_control_nxt;
  reg  [31:0]              rd_nxt;
  reg                      err_nxt;

  // power-down takes precedence when both requests are set
  assign pwrdn_mode = power_control_reg[`MCPR_PWRCTL_DOWN];
  assign idle_mode  = power_control_reg[`MCPR_PWRCTL_IDLE] & ~pwrdn_mode;

  // with the oscillator stopped the pin is sampled on every clock so reset can wake it
  assign rst_sample = state5_phase2 | pwrdn_mode;

  assign access  = psel & penable & ~pready;
  assign wr_done = psel & penable & pready & pwrite;

  mcpr_timing u_timing (
    .clock      (clock),
    .resetn     (resetn),
    .osc_in     (osc_input_pin),
    .run        (~pwrdn_mode),
    .osc_edge_r (osc_edge),
    .int_clk_r  (int_clk),
    .phase_r    (phase),
    .state5_phase2_r (state5_phase2)
  );

  mcpr_rst_filter u_rst_filter (
    .clock        (clock),
    .resetn       (resetn),
    .rst_pin      (rst_pin),
    .sample       (rst_sample),
    .rst_active_r (rst_active)
  );

  // power control next value
  always @* begin
    power_control_nxt = power_control_reg;
    if (wr_done && paddr == `MCPR_OFS_PWRCTL)
      power_control_nxt = pwdata[7:0];
    // interrupt wake clears idle only; power-down ignores it
    if (irq_pending && !pwrdn_mode)
      power_control_nxt[`MCPR_PWRCTL_IDLE] = 1'b0;
    if (rst_active)
      power_control_nxt = (power_control_reg & `MCPR_PWRCTL_KEEP_MASK) | `MCPR_PWRCTL_RST;
  end

  // read mux and decode
  always @* begin
    rd_nxt  = 32'h00000000;
    err_nxt = 1'b0;
    case (paddr)
      `MCPR_OFS_PWRCTL: rd_nxt = {24'h000000, power_control_reg};
      `MCPR_OFS_STATUS: rd_nxt = {24'h000000, rst_active, pwrdn_mode, idle_mode, int_clk, phase};
      `MCPR_OFS_SP:     rd_nxt = {24'h000000, stack_ptr};
      `MCPR_OFS_PORTS:  rd_nxt = port_latch;
      `MCPR_OFS_SPECFN: rd_nxt = {24'h000000, special_function_register};
      `MCPR_OFS_SERBUF: rd_nxt = {24'h000000, serial_buffer};
      default:          err_nxt = 1'b1;
    endcase
  end

  // apb handshake: one wait state per transfer
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= access;
      pslverr <= access & err_nxt;
      if (access && !pwrite)
        prdata <= rd_nxt;
    end
  end

  // reset-loaded registers
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      power_control_reg         <= `MCPR_PWRCTL_RST;
      port_latch                <= `MCPR_PORTS_RST;
      stack_ptr                 <= `MCPR_SP_RST;
      special_function_register <= `MCPR_SPECFN_RST;
    end else begin
      power_control_reg <= power_control_nxt;
      if (rst_active) begin
        port_latch                <= `MCPR_PORTS_RST;
        stack_ptr                 <= `MCPR_SP_RST;
        special_function_register <= `MCPR_SPECFN_RST;
      end else if (wr_done) begin
        if (paddr == `MCPR_OFS_PORTS)
          port_latch <= pwdata;
        if (paddr == `MCPR_OFS_SP)
          stack_ptr <= pwdata[7:0];
        if (paddr == `MCPR_OFS_SPECFN)
          special_function_register <= pwdata[7:0];
      end
    end
  end

  // serial buffer keeps its content through reset
  always @(posedge clock) begin
    if (wr_done && paddr == `MCPR_OFS_SERBUF)
      serial_buffer <= pwdata[7:0];
  end

  // clock gating and status outputs
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      osc_enable     <= 1'b1;
      cpu_clk        <= 1'b0;
      periph_clk     <= 1'b0;
      machine_strobe <= 1'b0;
      core_reset     <= 1'b0;
    end else begin
      osc_enable     <= ~pwrdn_mode;
      machine_strobe <= state5_phase2;
      core_reset     <= rst_active;
      if (osc_edge) begin
        periph_clk <= ~periph_clk;
        if (!idle_mode)
          cpu_clk <= ~cpu_clk;
      end
    end
  end
endmodule

// >>> shared/mcpr_defines.vh
`ifndef MCPR_DEFINES_VH
`define MCPR_DEFINES_VH

// machine cycle layout
`define MCPR_PHASES_PER_CYCLE 4'd12
`define MCPR_PHASE_LAST       4'd11
`define MCPR_PHASE_ST5PH2     4'd9
`define MCPR_PHASE_W          4

// reset filter
`define MCPR_RST_SAMPLES      2'd2

// register byte offsets
`define MCPR_OFS_PWRCTL       12'h000
`define MCPR_OFS_STATUS       12'h004
`define MCPR_OFS_SP           12'h008
`define MCPR_OFS_PORTS        12'h00c
`define MCPR_OFS_SPECFN       12'h010
`define MCPR_OFS_SERBUF       12'h014

// power control fields
`define MCPR_PWRCTL_IDLE      0
`define MCPR_PWRCTL_DOWN      1
`define MCPR_PWRCTL_KEEP      4
`define MCPR_PWRCTL_RST       8'h00
`define MCPR_PWRCTL_KEEP_MASK 8'h10

// reset values
`define MCPR_PORTS_RST        32'hffffffff
`define MCPR_SP_RST           8'h07
`define MCPR_SPECFN_RST       8'h00

`endif

// >>> rtl/mcpr_timing.v
`timescale 1ns/10ps
`include "mcpr_defines.vh"
// oscillator edge tracking, divide by two and machine cycle phases
module mcpr_timing (
  // clock and reset
  input  wire                      clock,
  input  wire                      resetn,
  // oscillator side
  input  wire                      osc_in,
  input  wire                      run,
  // timing outputs
  output reg                       osc_edge_r,
  output reg                       int_clk_r,
  output reg  [`MCPR_PHASE_W-1:0]  phase_r,
  output reg                       state5_phase2_r
);
  reg osc_d_r;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      osc_d_r    <= 1'b0;
      osc_edge_r <= 1'b0;
      int_clk_r  <= 1'b0;
      phase_r    <= {`MCPR_PHASE_W{1'b0}};
      state5_phase2_r <= 1'b0;
    end else begin
      osc_d_r    <= osc_in;
      // state holds while the oscillator stands still at either level
      osc_edge_r <= run & osc_in & ~osc_d_r;
      state5_phase2_r <= 1'b0;
      if (run && osc_in && !osc_d_r) begin
        int_clk_r <= ~int_clk_r;
        if (phase_r == `MCPR_PHASE_LAST)
          phase_r <= {`MCPR_PHASE_W{1'b0}};
        else
          phase_r <= phase_r + 1'b1;
        state5_phase2_r <= (phase_r == `MCPR_PHASE_ST5PH2 - 1'b1);
      end
    end
  end
endmodule

// >>> rtl/mcpr_rst_filter.v
`timescale 1ns/10ps
`include "mcpr_defines.vh"
// reset pin deglitch: level must agree on consecutive samples
module mcpr_rst_filter (
  // clock and reset
  input  wire clock,
  input  wire resetn,
  // sampling
  input  wire rst_pin,
  input  wire sample,
  // filtered level
  output reg  rst_active_r
);
  reg [1:0] agree_r;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      agree_r      <= 2'd0;
      rst_active_r <= 1'b0;
    end else if (sample) begin
      // active high pin; a lone differing sample is a glitch
      if (rst_pin == rst_active_r) begin
        agree_r <= 2'd0;
      end else if (agree_r + 2'd1 >= `MCPR_RST_SAMPLES) begin
        agree_r      <= 2'd0;
        rst_active_r <= rst_pin;
      end else begin
        agree_r <= agree_r + 2'd1;
      end
    end
  end
endmodule

// >>> dv/mcpr_chk_asserts.sv
`timescale 1ns/10ps
module mcpr_chk (
  // clock and reset
  input wire        clock,
  input wire        resetn,
  // inputs
  input wire        rst_pin,
  input wire        irq_pending,
  input wire        psel,
  input wire        penable,
  // outputs
  input wire        pready,
  input wire        osc_enable,
  input wire        cpu_clk,
  input wire        periph_clk,
  input wire        machine_strobe,
  input wire        core_reset,
  input wire [31:0] port_latch,
  input wire [7:0]  stack_ptr,
  input wire [7:0]  power_control_reg
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  pwrdn_stop_a: assert property (!osc_enable && !$past(osc_enable) |-> $stable(cpu_clk) && $stable(periph_clk))
    else $error("clock runs in power-down");
  idle_stop_a: assert property (power_control_reg[0] && $past(power_control_reg[0]) |-> $stable(cpu_clk))
    else $error("cpu clock runs in idle");
  strobe_gap_a: assert property (machine_strobe |=> !machine_strobe [*8])
    else $error("strobe too close");
  rst_load_a: assert property (core_reset && $past(core_reset) |-> port_latch == 32'hffffffff
    && stack_ptr == 8'h07)
    else $error("reset values wrong");
  rst_power_a: assert property (core_reset && $past(core_reset) |-> (power_control_reg & 8'hef) == 8'h00
    && $stable(power_control_reg[4]))
    else $error("power control not reset");
  rst_rise_a: assert property ($rose(core_reset) |-> $past(rst_pin, 2))
    else $error("reset without filter");
  pwrdn_hold_a: assert property (power_control_reg[1] && !rst_pin && !psel |=> power_control_reg[1])
    else $error("power-down left");
  irq_wake_a: assert property (irq_pending && power_control_reg[1:0] == 2'h1 |-> ##[1:2] !power_control_reg[0])
    else $error("idle kept");
endmodule
bind mcpr_ctrl mcpr_chk chk (.*);

// >>> dv/mcpr_far_model.sv
`timescale 1ns/10ps
// oscillator, reset source and interrupt source
module mcpr_far_model (
  // clock
  input  wire clock,
  // requests
  input  wire osc_enable,
  input  wire rst_req,
  input  wire glitch,
  input  wire irq_req,
  // pins
  output reg  osc_input_pin = 1'b0,
  output reg  rst_pin = 1'b0,
  output reg  irq_pending = 1'b0
);
  reg       div_r = 1'b0;
  reg [7:0] hold_r = 8'h00;
  always @(posedge clock) begin
    div_r <= ~div_r;
    // oscillator stands at its level while disabled
    if (osc_enable && div_r)
      osc_input_pin <= ~osc_input_pin;
    hold_r <= rst_req ? 8'hc8 : hold_r - {7'h00, |hold_r};
    rst_pin <= rst_req | glitch | (|hold_r);
    irq_pending <= irq_req;
  end
endmodule

// >>> dv/mcpr_ctrl_tb.sv
`timescale 1ns/10ps
module mcpr_ctrl_tb;
  localparam [31:0] all1 = 32'hffffffff;
  localparam [31:0] lo8  = 32'h000000ff;
  reg         clock = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg         rst_req = 1'b0, glitch = 1'b0, irq_req = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0, seed = 32'h13, a, b;
  reg  [31:0] d [2:5];
  reg  [63:0] e;
  reg  [63:0] expq [$];
  wire        osc_input_pin, rst_pin, irq_pending, pready, pslverr;
  wire        osc_enable, cpu_clk, periph_clk, machine_strobe, core_reset;
  wire [31:0] prdata, port_latch;
  wire [7:0]  stack_ptr, power_control_reg, special_function_register, serial_buffer;
  integer     err_total = 0, cmp_count = 0, nosc = 0, ncpu = 0, i;
  always #5 clock = ~clock;
  always @(posedge osc_input_pin) nosc = nosc + 1;
  always @(cpu_clk) ncpu = ncpu + 1;
  mcpr_ctrl dut (.*);
  mcpr_far_model far (.*);
  function [31:0] xs(input [31:0] v);
    xs = v ^ (v << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("mismatch %0s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task results;
    if (err_total == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task wt(input integer n);
    repeat (n) @(posedge clock);
  endtask
  task apb(input w, input [11:0] ad, input [31:0] dt);
    integer n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= dt;
    @(posedge clock) penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 20) begin
      n = n + 1;
      @(posedge clock);
    end
    if (n == 20) err_total = err_total + 1;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task rd(input [11:0] ad, input [31:0] m, input [31:0] x);
    expq.push_back({m, x});
    apb(1'b0, ad, 32'h0);
  endtask
  // oldest expectation against each completed read
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
      e = expq.pop_front();
      chk("prdata", prdata & e[63:32], e[31:0]);
    end
    // only the six mapped words answer without error
    if (psel && penable && pready === 1'b1)
      chk("pslverr", {31'h0, pslverr}, {31'h0, paddr > 12'h014});
  end
  initial begin
    wt(2);
    resetn <= 1'b1;
    @(posedge clock);
    rd(12'h000, lo8, 32'h0);
    rd(12'h008, lo8, 32'h07);
    rd(12'h00c, all1, all1);
    rd(12'h010, lo8, 32'h0);
    rd(12'h020, all1, 32'h0);
    for (i = 2; i < 6; i = i + 1) begin
      seed = xs(seed);
      d[i] = seed & (i == 3 ? all1 : lo8);
      a = i * 4;
      apb(1'b1, a[11:0], seed);
      rd(a[11:0], all1, d[i]);
    end
    @(posedge osc_input_pin);
    wt(3);
    a = nosc;
    b = ncpu;
    wt(96);
    chk("cpu_clk", ncpu - b, nosc - a);
    apb(1'b1, 12'h000, 32'h11);
    rd(12'h004, 32'h60, 32'h20);
    wt(20);
    irq_req <= 1'b1;
    wt(4);
    irq_req <= 1'b0;
    rd(12'h000, lo8, 32'h10);
    rst_req <= 1'b1;
    @(posedge clock) rst_req <= 1'b0;
    wt(140);
    apb(1'b1, 12'h008, 32'h55);
    rd(12'h008, lo8, 32'h07);
    wt(200);
    rd(12'h000, lo8, 32'h10);
    rd(12'h00c, all1, all1);
    rd(12'h010, lo8, 32'h0);
    rd(12'h014, lo8, d[5]);
    apb(1'b1, 12'h008, 32'h5a);
    glitch <= 1'b1;
    @(posedge clock) glitch <= 1'b0;
    wt(100);
    rd(12'h008, lo8, 32'h5a);
    apb(1'b1, 12'h000, 32'h03);
    rd(12'h004, 32'h60, 32'h40);
    irq_req <= 1'b1;
    wt(4);
    irq_req <= 1'b0;
    rd(12'h000, lo8, 32'h03);
    rst_req <= 1'b1;
    @(posedge clock) rst_req <= 1'b0;
    wt(250);
    rd(12'h000, lo8, 32'h0);
    wt(2);
    results;
  end
  initial begin
    #50000;
    err_total = err_total + 1;
    results;
  end
endmodule
